// ---- design/fsd_defines.svh ----
// Behaviour
// (R01) Set bad-track flag when read cylinder differs from expected and equals all ones.
// (R02) Set missing-data-mark flag when a read finds no normal or deleted data mark.
// (R03) Drive-status byte reports the fault input level when the byte is produced.
// (R04) Drive-status byte mirrors the write-protect input level.
// (R05) Drive-status byte mirrors the ready input level.
// (R06) Drive-status byte mirrors the outermost-track indicator input.
// (R07) Drive-status byte mirrors the double-sided indicator input.
// (R08) Drive-status byte reports the level driven on the side-select output.
// (R09) Drive-status byte reports both drive-unit select output levels.
// (R10) Port-group strap high selects the primary port group, fixed-disk status port included.
// (R11) Reads and writes decode apart: drive type, output control, input status versus rate.
// (R12) Drive type register shows both density straps; one is high density, zero double.
// (R13) Fixed-disk status bit 7 returns the hard-disk presence strap level.
// (R14) Port-group strap low selects the secondary port group instead.
// (R15) Drive-status bits 7..0: fault, protect, ready, track zero, two-sided, side, unit1, unit0.
`ifndef FSD_DEFINES_SVH
`define FSD_DEFINES_SVH

// ****************************************
// primary and secondary port addresses
// ****************************************
`define FSD_PRI_DTYPE 10'h3F1
`define FSD_PRI_DOR 10'h3F2
`define FSD_PRI_MSR 10'h3F4
`define FSD_PRI_DATA 10'h3F6
`define FSD_PRI_DIR 10'h3F7
`define FSD_PRI_FDSTAT 10'h1F7
`define FSD_SEC_DTYPE 10'h371
`define FSD_SEC_DOR 10'h372
`define FSD_SEC_DATA 10'h375
`define FSD_SEC_DIR 10'h377
`define FSD_SEC_FDSTAT 10'h177

// ****************************************
// field positions
// ****************************************
`define FSD_ST2_BAD_TRACK 1
`define FSD_ST2_MISSING_DM 0
`define FSD_FDSTAT_STRAP 7
`define FSD_DOR_UNIT_LSB 0
`define FSD_DOR_CORE_RUN 2
`define FSD_DOR_DMA_EN 3
`define FSD_DOR_MOTOR_LSB 4
`define FSD_RATE_LSB 0

// ****************************************
// constants and reset values
// ****************************************
`define FSD_CYL_ALL_ONES 8'hFF
`define FSD_DOR_RESET 8'h00
`define FSD_RATE_RESET 2'h0
`define FSD_BYTE_ZERO 8'h00

`endif

// ---- design/fsd_pkg.sv ----
package fsd_pkg;

   // ****************************************
   // types
   // ****************************************
   typedef enum logic [2:0] {
      FSD_PORT_NONE,
      FSD_PORT_DTYPE,
      FSD_PORT_DOR,
      FSD_PORT_MSR,
      FSD_PORT_DATA,
      FSD_PORT_DIR,
      FSD_PORT_FDSTAT
   } fsd_port_e;

   typedef struct packed {
      logic [9:0] addr;
      logic rd;
      logic wr;
      logic [7:0] wdata;
   } fsd_io_req_s;

   typedef struct packed {
      logic drive_fault_state;
      logic write_protect_state;
      logic ready_state;
      logic outer_track_state;
      logic double_sided_state;
   } fsd_drive_in_s;

   typedef struct packed {
      logic id_valid;
      logic [7:0] id_cylinder;
      logic [7:0] expected_sector_id;
      logic data_mark_missing;
      logic status_clear;
      logic sense_request;
      logic side_select;
   } fsd_seq_s;

endpackage : fsd_pkg

// ---- design/fsd_status_decode.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "fsd_defines.svh"

module fsd_status_decode
   import fsd_pkg::*;
(
   input wire logic clock,
   input wire logic nrst,
   input wire fsd_io_req_s io_req,
   output logic [7:0] io_rdata,
   output logic io_rdata_oe,
   input wire logic port_group_strap,
   input wire logic [1:0] density_strap,
   input wire logic hard_disk_presence_strap,
   input wire fsd_drive_in_s drive_in,
   input wire logic disk_change,
   input wire fsd_seq_s seq,
   input wire logic [7:0] seq_main_status,
   input wire logic [7:0] seq_data_byte,
   output logic data_rd_pulse,
   output logic data_wr_pulse,
   output logic [7:0] data_wr_byte,
   output logic [7:0] result_status_two,
   output logic [7:0] drive_signal_status,
   output logic side_select_state,
   output logic unit_select_hi_state,
   output logic unit_select_lo_state,
   output logic [1:0] motor_on,
   output logic dma_enable,
   output logic core_run_n,
   output logic [1:0] rate_select
);

   // ****************************************
   // port decode
   // ****************************************
   // strap is sampled every access; changing it mid-access is the board's problem
   function automatic fsd_port_e decode_port(input logic [9:0] addr, input logic primary);
      fsd_port_e p;
      p = FSD_PORT_NONE;
      if (primary) begin // [R10]
         unique case (addr)
            `FSD_PRI_DTYPE: p = FSD_PORT_DTYPE;
            `FSD_PRI_DOR: p = FSD_PORT_DOR;
            `FSD_PRI_MSR: p = FSD_PORT_MSR;
            `FSD_PRI_DATA: p = FSD_PORT_DATA;
            `FSD_PRI_DIR: p = FSD_PORT_DIR;
            `FSD_PRI_FDSTAT: p = FSD_PORT_FDSTAT;
            default: p = FSD_PORT_NONE;
         endcase
      end else begin // [R14]
         // no main status port exists in the secondary group
         unique case (addr)
            `FSD_SEC_DTYPE: p = FSD_PORT_DTYPE;
            `FSD_SEC_DOR: p = FSD_PORT_DOR;
            `FSD_SEC_DATA: p = FSD_PORT_DATA;
            `FSD_SEC_DIR: p = FSD_PORT_DIR;
            `FSD_SEC_FDSTAT: p = FSD_PORT_FDSTAT;
            default: p = FSD_PORT_NONE;
         endcase
      end
      return p;
   endfunction : decode_port

   fsd_port_e port;
   logic rd_hit;
   logic wr_hit;

   always_comb begin
      port = decode_port(io_req.addr, port_group_strap);
      rd_hit = io_req.rd && (port != FSD_PORT_NONE) && (port != FSD_PORT_DOR); // [R11]
      wr_hit = io_req.wr;
   end

   // handshake strobes toward the command sequencer
   assign data_rd_pulse = io_req.rd && (port == FSD_PORT_DATA);
   assign data_wr_pulse = io_req.wr && (port == FSD_PORT_DATA);

   // ****************************************
   // host read path
   // ****************************************
   logic [7:0] next_io_rdata;
   logic next_io_rdata_oe;

   always_comb begin
      next_io_rdata = `FSD_BYTE_ZERO;
      next_io_rdata_oe = rd_hit;
      if (io_req.rd) begin
         unique case (port)
            FSD_PORT_DTYPE: next_io_rdata = {6'h00, density_strap}; // [R11] [R12]
            FSD_PORT_MSR: next_io_rdata = seq_main_status;
            FSD_PORT_DATA: next_io_rdata = seq_data_byte;
            FSD_PORT_DIR: next_io_rdata = {disk_change, 7'h00}; // [R11]
            FSD_PORT_FDSTAT: begin
               next_io_rdata = `FSD_BYTE_ZERO;
               next_io_rdata[`FSD_FDSTAT_STRAP] = hard_disk_presence_strap; // [R13]
            end
            default: next_io_rdata = `FSD_BYTE_ZERO;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         io_rdata <= `FSD_BYTE_ZERO;
         io_rdata_oe <= 1'b0;
      end else begin
         io_rdata <= next_io_rdata;
         io_rdata_oe <= next_io_rdata_oe;
      end
   end

   // ****************************************
   // host write path
   // ****************************************
   logic [7:0] dor;
   logic [7:0] next_dor;
   logic [1:0] next_rate_select;
   logic [7:0] next_data_wr_byte;

   always_comb begin
      next_dor = dor;
      next_rate_select = rate_select;
      next_data_wr_byte = data_wr_byte;
      if (wr_hit) begin
         unique case (port)
            FSD_PORT_DOR: next_dor = io_req.wdata; // [R11]
            FSD_PORT_DIR: next_rate_select = io_req.wdata[`FSD_RATE_LSB +: 2]; // [R11]
            FSD_PORT_DATA: next_data_wr_byte = io_req.wdata;
            default: next_dor = dor;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         dor <= `FSD_DOR_RESET;
         rate_select <= `FSD_RATE_RESET;
         data_wr_byte <= `FSD_BYTE_ZERO;
      end else begin
         dor <= next_dor;
         rate_select <= next_rate_select;
         data_wr_byte <= next_data_wr_byte;
      end
   end

   assign unit_select_lo_state = dor[`FSD_DOR_UNIT_LSB];
   assign unit_select_hi_state = dor[`FSD_DOR_UNIT_LSB + 1];
   assign motor_on = dor[`FSD_DOR_MOTOR_LSB +: 2];
   assign dma_enable = dor[`FSD_DOR_DMA_EN];
   // core held in reset until software sets the run bit
   assign core_run_n = ~dor[`FSD_DOR_CORE_RUN];

   // ****************************************
   // result status two
   // ****************************************
   logic bad_track_flag;
   logic missing_data_mark_flag;
   logic next_bad_track_flag;
   logic next_missing_data_mark_flag;
   logic bad_track_event;

   always_comb begin
      bad_track_event = seq.id_valid
         && (seq.id_cylinder != seq.expected_sector_id)
         && (seq.id_cylinder == `FSD_CYL_ALL_ONES); // [R01]
      next_bad_track_flag = bad_track_flag;
      next_missing_data_mark_flag = missing_data_mark_flag;
      if (seq.status_clear) begin
         next_bad_track_flag = 1'b0;
         next_missing_data_mark_flag = 1'b0;
      end
      // set after clear so an event in the clearing cycle is kept
      if (bad_track_event) begin
         next_bad_track_flag = 1'b1; // [R01]
      end
      if (seq.data_mark_missing) begin
         next_missing_data_mark_flag = 1'b1; // [R02]
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         bad_track_flag <= 1'b0;
         missing_data_mark_flag <= 1'b0;
      end else begin
         bad_track_flag <= next_bad_track_flag;
         missing_data_mark_flag <= next_missing_data_mark_flag;
      end
   end

   always_comb begin
      result_status_two = `FSD_BYTE_ZERO;
      result_status_two[`FSD_ST2_BAD_TRACK] = bad_track_flag;
      result_status_two[`FSD_ST2_MISSING_DM] = missing_data_mark_flag;
   end

   // ****************************************
   // drive signal status and side select
   // ****************************************
   logic [7:0] next_drive_signal_status;
   logic next_side_select_state;

   always_comb begin
      next_side_select_state = seq.side_select;
      next_drive_signal_status = drive_signal_status;
      // snapshot when the byte is produced, so it is stable while read out
      if (seq.sense_request) begin
         next_drive_signal_status = {
            drive_in.drive_fault_state, // [R03] [R15]
            drive_in.write_protect_state, // [R04]
            drive_in.ready_state, // [R05]
            drive_in.outer_track_state, // [R06]
            drive_in.double_sided_state, // [R07]
            side_select_state, // [R08]
            unit_select_hi_state, // [R09]
            unit_select_lo_state
         };
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         drive_signal_status <= `FSD_BYTE_ZERO;
         side_select_state <= 1'b0;
      end else begin
         drive_signal_status <= next_drive_signal_status;
         side_select_state <= next_side_select_state;
      end
   end

   // ****************************************
   // assertions
   // ****************************************
   a_bad_track_set: assert property (@(posedge clock) disable iff (!nrst) // [R01]
      (seq.id_valid && seq.id_cylinder == `FSD_CYL_ALL_ONES
         && seq.expected_sector_id != `FSD_CYL_ALL_ONES)
      |=> bad_track_flag)
      else $error("bad track flag not set");

   a_bad_track_quiet: assert property (@(posedge clock) disable iff (!nrst) // [R01]
      (!bad_track_flag && (!seq.id_valid || seq.id_cylinder != `FSD_CYL_ALL_ONES))
      |=> !bad_track_flag)
      else $error("bad track flag set without cause");

   a_missing_mark_set: assert property (@(posedge clock) disable iff (!nrst) // [R02]
      seq.data_mark_missing |=> result_status_two[0] ##1 (result_status_two[0] || $past(seq.status_clear)))
      else $error("missing data mark flag not held");

   a_dss_snapshot: assert property (@(posedge clock) disable iff (!nrst) // [R03]
      seq.sense_request |=> (drive_signal_status[7:3] == $past(drive_in)
         && drive_signal_status[1:0] == $past(dor[1:0])))
      else $error("drive status snapshot wrong");

   a_dss_side: assert property (@(posedge clock) disable iff (!nrst) // [R08]
      ($past(seq.side_select) == 1'b1 && seq.sense_request) |=> drive_signal_status[2])
      else $error("side select not reported");

   a_primary_dtype: assert property (@(posedge clock) disable iff (!nrst) // [R12]
      (io_req.rd && port_group_strap && io_req.addr == `FSD_PRI_DTYPE)
      |=> (io_rdata_oe && io_rdata == {6'h00, $past(density_strap)}))
      else $error("drive type read wrong");

   a_secondary_only: assert property (@(posedge clock) disable iff (!nrst) // [R14]
      (io_req.rd && !port_group_strap && io_req.addr == `FSD_PRI_DTYPE) |=> !io_rdata_oe)
      else $error("primary port answered in secondary mode");

   a_fixed_disk_bit: assert property (@(posedge clock) disable iff (!nrst) // [R13]
      (io_req.rd && !port_group_strap && io_req.addr == `FSD_SEC_FDSTAT)
      |=> (io_rdata_oe && io_rdata[7] == $past(hard_disk_presence_strap)))
      else $error("fixed disk status wrong");

   a_dor_write_only: assert property (@(posedge clock) disable iff (!nrst) // [R11]
      (io_req.rd && port_group_strap && io_req.addr == `FSD_PRI_DOR) |=> !io_rdata_oe)
      else $error("output control port answered a read");

   a_rate_write: assert property (@(posedge clock) disable iff (!nrst) // [R11]
      (io_req.wr && port_group_strap && io_req.addr == `FSD_PRI_DIR)
      |=> (rate_select == $past(io_req.wdata[1:0]) && $stable(unit_select_lo_state)))
      else $error("rate select write lost");

   a_unit_write: assert property (@(posedge clock) disable iff (!nrst) // [R09]
      (io_req.wr && port_group_strap && io_req.addr == `FSD_PRI_DOR)
      |=> ({unit_select_hi_state, unit_select_lo_state} == $past(io_req.wdata[1:0])))
      else $error("unit select write lost");

   a_fdstat_primary: assert property (@(posedge clock) disable iff (!nrst) // [R10]
      (io_req.rd && port_group_strap && io_req.addr == `FSD_PRI_FDSTAT)
      |=> (io_rdata_oe && io_rdata[`FSD_FDSTAT_STRAP] == $past(hard_disk_presence_strap)))
      else $error("primary fixed disk status wrong");

   a_data_read: assert property (@(posedge clock) disable iff (!nrst) // [R10]
      (io_req.rd && port_group_strap && io_req.addr == `FSD_PRI_DATA)
      |=> (io_rdata_oe && io_rdata == $past(seq_data_byte)))
      else $error("data port read wrong");

   a_dss_hold: assert property (@(posedge clock) disable iff (!nrst) // [R03]
      !seq.sense_request |=> $stable(drive_signal_status))
      else $error("drive status moved without a sense request");

   a_missing_mark_clear: assert property (@(posedge clock) disable iff (!nrst) // [R02]
      (seq.status_clear && !seq.data_mark_missing) |=> !missing_data_mark_flag)
      else $error("missing data mark flag not cleared");

endmodule : fsd_status_decode

`default_nettype wire

// ---- dv/fsd_host_model.sv ----
`timescale 1ns/10ps
`default_nettype none

// ****************************************
// host side of the i/o bus
// ****************************************
module fsd_host_model
   import fsd_pkg::*;
(
   input wire logic clock,
   output var fsd_io_req_s io_req,
   input wire logic [7:0] io_rdata,
   input wire logic io_rdata_oe
);
   initial io_req = '0;

   // released address and data flip, so a stale value never looks valid
   task automatic rd(input logic [9:0] a, output logic [7:0] d, output logic oe);
      @(negedge clock);
      io_req.addr = a;
      io_req.rd = 1'b1;
      @(negedge clock);
      d = io_rdata;
      oe = io_rdata_oe;
      io_req.rd = 1'b0;
      io_req.addr = ~a;
   endtask : rd

   task automatic wr(input logic [9:0] a, input logic [7:0] dat);
      @(negedge clock);
      io_req.addr = a;
      io_req.wdata = dat;
      io_req.wr = 1'b1;
      @(negedge clock);
      io_req.wr = 1'b0;
      io_req.addr = ~a;
      io_req.wdata = ~dat;
   endtask : wr
endmodule : fsd_host_model

`default_nettype wire

// ---- dv/tb_fsd_status_decode.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "fsd_defines.svh"

module tb_fsd_status_decode
   import fsd_pkg::*;
;
   localparam logic [7:0] MAIN_STAT = 8'h5a;
   localparam logic [9:0] SEC_MSR = 10'h374;
   localparam logic [7:0] DATA_BYTE = 8'h3c;
   logic clock, nrst, port_group_strap, hard_disk_presence_strap, disk_change;
   logic [1:0] density_strap, motor_on, rate_select;
   fsd_drive_in_s drive_in;
   fsd_seq_s seq;
   fsd_io_req_s io_req;
   logic [7:0] io_rdata, result_status_two, drive_signal_status, data_wr_byte;
   logic io_rdata_oe, side_select_state, unit_select_hi_state, unit_select_lo_state;
   logic dma_enable, core_run_n, data_rd_pulse, data_wr_pulse;
   int fail_count, n_tests, cyc, n_rd_pulse, n_wr_pulse;

   // ****************************************
   // design and host
   // ****************************************
   fsd_status_decode i_fsd_status_decode (
      .clock(clock), .nrst(nrst), .io_req(io_req), .io_rdata(io_rdata),
      .io_rdata_oe(io_rdata_oe), .port_group_strap(port_group_strap),
      .density_strap(density_strap), .hard_disk_presence_strap(hard_disk_presence_strap),
      .drive_in(drive_in), .disk_change(disk_change), .seq(seq),
      .seq_main_status(MAIN_STAT), .seq_data_byte(DATA_BYTE),
      .data_rd_pulse(data_rd_pulse), .data_wr_pulse(data_wr_pulse),
      .data_wr_byte(data_wr_byte), .result_status_two(result_status_two),
      .drive_signal_status(drive_signal_status), .side_select_state(side_select_state),
      .unit_select_hi_state(unit_select_hi_state),
      .unit_select_lo_state(unit_select_lo_state), .motor_on(motor_on),
      .dma_enable(dma_enable), .core_run_n(core_run_n), .rate_select(rate_select));

   fsd_host_model i_fsd_host_model (
      .clock(clock), .io_req(io_req), .io_rdata(io_rdata), .io_rdata_oe(io_rdata_oe));

   // ****************************************
   // helpers
   // ****************************************
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic rdchk(input logic [9:0] a, input logic eo, input logic [7:0] ed);
      logic [7:0] d;
      logic oe;
      i_fsd_host_model.rd(a, d, oe);
      chk(8'(oe), 8'(eo));
      chk(d, ed);
   endtask : rdchk

   task automatic wrx(input logic [9:0] a, input logic [7:0] dat);
      i_fsd_host_model.wr(a, dat);
      @(negedge clock);
   endtask : wrx

   // idle cycle, then a one-cycle sequencer event, result seen at the next falling edge
   task automatic ev(input logic iv, input logic [7:0] c, e, input logic dm, clr, sns);
      @(negedge clock);
      seq.id_valid = iv;
      seq.id_cylinder = c;
      seq.expected_sector_id = e;
      seq.data_mark_missing = dm;
      seq.status_clear = clr;
      seq.sense_request = sns;
      @(negedge clock);
      seq.id_valid = 1'b0;
      seq.data_mark_missing = 1'b0;
      seq.status_clear = 1'b0;
      seq.sense_request = 1'b0;
      seq.id_cylinder = ~c;
   endtask : ev

   task automatic summarize();
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : summarize

   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end

   // ceiling well above the roughly 90 cycles the tests need
   always @(posedge clock) begin
      if (data_rd_pulse === 1'b1) begin
         n_rd_pulse++;
      end
      if (data_wr_pulse === 1'b1) begin
         n_wr_pulse++;
      end
      cyc++;
      if (cyc == 3000) begin
         fail_count++;
         $display("unexpected at %0t: timeout", $time);
         summarize();
      end
   end

   // ****************************************
   // tests
   // ****************************************
   initial begin
      nrst = 1'b0;
      port_group_strap = 1'b1;
      density_strap = 2'b10;
      hard_disk_presence_strap = 1'b1;
      disk_change = 1'b1;
      drive_in = '0;
      seq = '0;
      repeat (5) @(negedge clock);
      nrst = 1'b1;
      chk(8'(io_rdata_oe), 8'h00);
      chk(8'(core_run_n), 8'h01);
      for (int g = 1; g >= 0; g--) begin
         port_group_strap = g[0];
         rdchk(g ? `FSD_PRI_DTYPE : `FSD_SEC_DTYPE, 1'b1, {6'h0, density_strap});
         rdchk(g ? `FSD_SEC_DTYPE : `FSD_PRI_DTYPE, 1'b0, 8'h00);
         rdchk(g ? `FSD_PRI_FDSTAT : `FSD_SEC_FDSTAT, 1'b1, 8'h80);
         hard_disk_presence_strap = 1'b0;
         rdchk(g ? `FSD_PRI_FDSTAT : `FSD_SEC_FDSTAT, 1'b1, 8'h00);
         hard_disk_presence_strap = 1'b1;
         rdchk(g ? `FSD_PRI_DOR : `FSD_SEC_DOR, 1'b0, 8'h00);
         rdchk(g ? `FSD_PRI_DIR : `FSD_SEC_DIR, 1'b1, {disk_change, 7'h0});
         rdchk(g ? `FSD_PRI_MSR : SEC_MSR, g[0], g ? MAIN_STAT : 8'h00);
         rdchk(g ? `FSD_PRI_DATA : `FSD_SEC_DATA, 1'b1, DATA_BYTE);
         wrx(g ? `FSD_PRI_DATA : `FSD_SEC_DATA, g ? 8'ha5 : 8'h5a);
         chk(data_wr_byte, g ? 8'ha5 : 8'h5a);
         wrx(g ? `FSD_PRI_DOR : `FSD_SEC_DOR, g ? 8'h01 : 8'h02);
         chk({6'h0, unit_select_hi_state, unit_select_lo_state}, g ? 8'h01 : 8'h02);
         wrx(g ? `FSD_PRI_DIR : `FSD_SEC_DIR, g ? 8'h02 : 8'h01);
         chk({6'h0, rate_select}, g ? 8'h02 : 8'h01);
         density_strap = 2'b01;
         disk_change = 1'b0;
      end
      chk(8'(n_rd_pulse), 8'h02);
      chk(8'(n_wr_pulse), 8'h02);
      // snapshot must hold while the drive lines move afterwards
      for (int i = 0; i < 2; i++) begin
         wrx(`FSD_SEC_DOR, i ? 8'h01 : 8'h02);
         drive_in = i ? 5'b01001 : 5'b10110;
         seq.side_select = i ? 1'b0 : 1'b1;
         repeat (2) @(negedge clock);
         ev(1'b0, 8'h00, 8'h00, 1'b0, 1'b0, 1'b1);
         chk(drive_signal_status, {drive_in, seq.side_select, ~i[0], i[0]});
         drive_in = ~drive_in;
         @(negedge clock);
         chk(drive_signal_status, {~drive_in, seq.side_select, ~i[0], i[0]});
      end
      wrx(`FSD_SEC_DOR, 8'h3c);
      chk({2'b00, motor_on, dma_enable, core_run_n, unit_select_hi_state,
         unit_select_lo_state}, 8'h38);
      ev(1'b0, 8'h00, 8'h00, 1'b0, 1'b1, 1'b0);
      chk(result_status_two, 8'h00);
      ev(1'b1, 8'hff, 8'h03, 1'b0, 1'b0, 1'b0);
      chk(result_status_two, 8'h02);
      ev(1'b0, 8'h00, 8'h00, 1'b0, 1'b1, 1'b0);
      ev(1'b1, 8'hff, 8'hff, 1'b0, 1'b0, 1'b0);
      chk(result_status_two, 8'h00);
      ev(1'b1, 8'hfe, 8'h03, 1'b0, 1'b0, 1'b0);
      chk(result_status_two, 8'h00);
      ev(1'b0, 8'h00, 8'h00, 1'b1, 1'b0, 1'b0);
      chk(result_status_two, 8'h01);
      ev(1'b1, 8'hff, 8'h00, 1'b0, 1'b1, 1'b0);
      chk(result_status_two, 8'h02);
      // second reset mid-run must bring every register back
      nrst = 1'b0;
      @(negedge clock);
      nrst = 1'b1;
      chk(result_status_two, `FSD_BYTE_ZERO);
      chk(drive_signal_status, `FSD_BYTE_ZERO);
      chk({motor_on, dma_enable, core_run_n, rate_select, unit_select_hi_state,
         unit_select_lo_state}, 8'h10);
      rdchk(`FSD_SEC_DTYPE, 1'b1, 8'h01);
      summarize();
   end
endmodule : tb_fsd_status_decode

`default_nettype wire
